// ---- pdc_top.v ----
// Two-channel peripheral DMA block with an AHB-Lite register slave and a
// shared transfer engine that borrows the register-file bus from the CPU.
// Assumes one 100 MHz clock, a register-file memory that returns read
// data one cycle after MEM_RE, and trigger inputs synchronous to CLK.
//
// Added by the designer: the AHB-Lite slave port.
`timescale 1ns/100ps
`include "pdc_consts.vh"

module pdc_top
(
    // Clock and reset.
    input wire CLK,
    input wire RESETN,
    // AHB-Lite slave.
    input wire HSEL,
    input wire [31:0] HADDR,
    input wire [1:0] HTRANS,
    input wire HWRITE,
    input wire [2:0] HSIZE,
    input wire [31:0] HWDATA,
    input wire HREADY,
    output reg HREADYOUT,
    output reg HRESP,
    output reg [31:0] HRDATA,
    // System bus arbitration with the CPU.
    output reg BUS_REQ,
    input wire BUS_ACK,
    // Register-file memory port, used only while the bus is granted.
    output reg [11:0] MEM_ADDR,
    output reg MEM_RE,
    output reg MEM_WE,
    output reg [7:0] MEM_WDATA,
    input wire [7:0] MEM_RDATA,
    // Trigger sources.
    input wire [3:0] TIMER_REQ,
    input wire UART0_RX_VALID,
    input wire UART0_TX_EMPTY,
    input wire UART1_RX_VALID,
    input wire UART1_TX_EMPTY,
    input wire I2C_RX_REQ,
    input wire I2C_TX_EMPTY,
    // Interrupt requests to the interrupt controller.
    output reg CH0_IRQ,
    output reg CH1_IRQ
);

    // ============================================================
    // Engine states.
    localparam ST_IDLE = 3'd0;
    localparam ST_GRANT = 3'd1;
    localparam ST_READ = 3'd2;
    localparam ST_COPY = 3'd3;
    localparam ST_WRITE = 3'd4;
    localparam ST_FINISH = 3'd5;

    // ============================================================
    // Decode helpers.

    // True when a word index names one of the channel registers.
    function reg_hit;
        input [11:0] idx;
        begin
            reg_hit = ({idx[11:4], 4'h0} ==
                       (`PDC_IDX_CH0_CONTROL & 12'hff0)) &&
                      (idx[2:0] <= `PDC_SEL_END);
        end
    endfunction

    // Byte-lane address of one step of a transfer.
    function [11:0] step_addr;
        input [11:0] base;
        input second;
        begin
            step_addr = base + {11'h000, second};
        end
    endfunction

    // ============================================================
    // Bus slave state.
    reg wr_pend_r;
    reg [11:0] wr_idx_r;
    wire addr_phase;
    wire [11:0] a_idx;
    wire wr_fire;
    wire [7:0] rd0;
    wire [7:0] rd1;
    reg [7:0] rd_mux;

    // Engine state.
    reg [2:0] state_r;
    reg chan_r;
    reg second_r;
    reg take0_r;
    reg take1_r;
    reg done0_r;
    reg done1_r;
    wire pend0;
    wire pend1;
    wire dir0;
    wire dir1;
    wire word0;
    wire word1;
    wire [11:0] per0;
    wire [11:0] per1;
    wire [11:0] cur0;
    wire [11:0] cur1;
    wire irq0;
    wire irq1;
    wire sel_dir;
    wire sel_word;
    wire [11:0] src_addr;
    wire [11:0] dst_addr;
    wire [6:0] trig0;
    wire [6:0] trig1;

    // ============================================================
    // Trigger wiring: each channel sees its own direction of UART/I2C.
    assign trig0 = {I2C_RX_REQ, UART1_RX_VALID, UART0_RX_VALID,
                    TIMER_REQ};
    assign trig1 = {I2C_TX_EMPTY, UART1_TX_EMPTY, UART0_TX_EMPTY,
                    TIMER_REQ};

    // ============================================================
    // AHB-Lite address phase decode; registers take word index bits.
    assign addr_phase = HSEL && HREADY && HTRANS[1];
    assign a_idx = HADDR[13:2];
    assign wr_fire = wr_pend_r;

    // Read data is picked in the address phase so HRDATA can be a flop.
    always @*
    begin
        if (!reg_hit(a_idx) || HADDR[31:14] != 18'h00000)
            rd_mux = 8'h00;
        else if (a_idx[3])
            rd_mux = rd1;
        else
            rd_mux = rd0;
    end

    // Slave pipeline: zero wait states, always OKAY, unmapped reads zero.
    always @(posedge CLK)
    begin
        if (!RESETN)
        begin
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
            HRDATA <= 32'h00000000;
            wr_pend_r <= 1'b0;
            wr_idx_r <= 12'h000;
        end
        else
        begin
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
            wr_pend_r <= 1'b0;
            if (addr_phase && HWRITE)
            begin
                // Writes to unmapped words are dropped silently.
                wr_pend_r <= reg_hit(a_idx) &&
                             (HADDR[31:14] == 18'h00000);
                wr_idx_r <= a_idx;
            end
            if (addr_phase && !HWRITE)
                HRDATA <= {24'h000000, rd_mux};
        end
    end

    // ============================================================
    // Channels.
    pdc_channel u_ch0
    (
        .clk(CLK),
        .resetn(RESETN),
        .wr_en_i(wr_fire && !wr_idx_r[3]),
        .wr_sel_i(wr_idx_r[2:0]),
        .wr_data_i(HWDATA[7:0]),
        .rd_sel_i(a_idx[2:0]),
        .rd_data_o(rd0),
        .trig_i(trig0),
        .take_i(take0_r),
        .done_i(done0_r),
        .pend_o(pend0),
        .dir_o(dir0),
        .word_o(word0),
        .periph_addr_o(per0),
        .cur_addr_o(cur0),
        .irq_o(irq0)
    );

    pdc_channel u_ch1
    (
        .clk(CLK),
        .resetn(RESETN),
        .wr_en_i(wr_fire && wr_idx_r[3]),
        .wr_sel_i(wr_idx_r[2:0]),
        .wr_data_i(HWDATA[7:0]),
        .rd_sel_i(a_idx[2:0]),
        .rd_data_o(rd1),
        .trig_i(trig1),
        .take_i(take1_r),
        .done_i(done1_r),
        .pend_o(pend1),
        .dir_o(dir1),
        .word_o(word1),
        .periph_addr_o(per1),
        .cur_addr_o(cur1),
        .irq_o(irq1)
    );

    // ============================================================
    // Source and destination follow the owning channel's direction.
    assign sel_dir = chan_r ? dir1 : dir0;
    assign sel_word = chan_r ? word1 : word0;
    assign src_addr = step_addr(sel_dir ? (chan_r ? per1 : per0) :
                                (chan_r ? cur1 : cur0),
                                second_r);
    assign dst_addr = step_addr(sel_dir ? (chan_r ? cur1 : cur0) :
                                (chan_r ? per1 : per0),
                                second_r);

    // Transfer engine. Channel 0 wins when both are pending; the bus is
    // given back after every request so the CPU is never starved long.
    always @(posedge CLK)
    begin
        if (!RESETN)
        begin
            state_r <= ST_IDLE;
            chan_r <= 1'b0;
            second_r <= 1'b0;
            take0_r <= 1'b0;
            take1_r <= 1'b0;
            done0_r <= 1'b0;
            done1_r <= 1'b0;
            BUS_REQ <= 1'b0;
            MEM_ADDR <= 12'h000;
            MEM_RE <= 1'b0;
            MEM_WE <= 1'b0;
            MEM_WDATA <= 8'h00;
        end
        else
        begin
            take0_r <= 1'b0;
            take1_r <= 1'b0;
            done0_r <= 1'b0;
            done1_r <= 1'b0;
            MEM_RE <= 1'b0;
            MEM_WE <= 1'b0;
            case (state_r)
                ST_IDLE:
                begin
                    second_r <= 1'b0;
                    if (pend0 || pend1)
                    begin
                        chan_r <= !pend0;
                        take0_r <= pend0;
                        take1_r <= !pend0;
                        BUS_REQ <= 1'b1;
                        state_r <= ST_GRANT;
                    end
                end
                ST_GRANT:
                begin
                    // Memory is touched only once the CPU has let go.
                    if (BUS_ACK)
                    begin
                        MEM_ADDR <= src_addr;
                        MEM_RE <= 1'b1;
                        state_r <= ST_READ;
                    end
                end
                ST_READ:
                    state_r <= ST_COPY;
                ST_COPY:
                begin
                    MEM_ADDR <= dst_addr;
                    MEM_WDATA <= MEM_RDATA;
                    MEM_WE <= 1'b1;
                    state_r <= ST_WRITE;
                end
                ST_WRITE:
                begin
                    if (sel_word && !second_r)
                    begin
                        // Second byte of a word at address plus one.
                        second_r <= 1'b1;
                        state_r <= ST_FINISH;
                    end
                    else
                    begin
                        BUS_REQ <= 1'b0;
                        done0_r <= !chan_r;
                        done1_r <= chan_r;
                        state_r <= ST_IDLE;
                    end
                end
                ST_FINISH:
                begin
                    MEM_ADDR <= src_addr;
                    MEM_RE <= 1'b1;
                    state_r <= ST_READ;
                end
                default:
                    state_r <= ST_IDLE;
            endcase
        end
    end

    // ============================================================
    // Interrupt requests are registered one more time to sit on flops.
    always @(posedge CLK)
    begin
        if (!RESETN)
        begin
            CH0_IRQ <= 1'b0;
            CH1_IRQ <= 1'b0;
        end
        else
        begin
            CH0_IRQ <= irq0;
            CH1_IRQ <= irq1;
        end
    end

endmodule

// ---- pdc_consts.vh ----
// Constants for the two-channel peripheral DMA block: register indexes,
// control field positions, reset values and trigger codes.
// Assumes inclusion by bare name from the design files of this block.
`ifndef PDC_CONSTS_VH
`define PDC_CONSTS_VH

// ============================================================
// Register indexes; byte address on the bus is four times the index.
`define PDC_IDX_CH0_CONTROL 12'hfb0
`define PDC_IDX_CH0_PERIPH 12'hfb1
`define PDC_IDX_CH0_UPPER 12'hfb2
`define PDC_IDX_CH0_START 12'hfb3
`define PDC_IDX_CH0_END 12'hfb4
`define PDC_IDX_CH1_CONTROL 12'hfb8
`define PDC_IDX_CH1_PERIPH 12'hfb9
`define PDC_IDX_CH1_UPPER 12'hfba
`define PDC_IDX_CH1_START 12'hfbb
`define PDC_IDX_CH1_END 12'hfbc

// ============================================================
// Register select inside one channel (low three index bits).
`define PDC_SEL_CONTROL 3'h0
`define PDC_SEL_PERIPH 3'h1
`define PDC_SEL_UPPER 3'h2
`define PDC_SEL_START 3'h3
`define PDC_SEL_END 3'h4

// ============================================================
// Control register fields.
`define PDC_CTL_ENABLE 7
`define PDC_CTL_LOOP 6
`define PDC_CTL_DIR 5
`define PDC_CTL_IRQ_EN 4
`define PDC_CTL_WORD 3
`define PDC_CTL_TRIG_HI 2
`define PDC_CTL_TRIG_LO 0
`define PDC_CTL_RESET 8'h00

// ============================================================
// Trigger codes and peripheral page.
`define PDC_TRIG_NONE 3'h7
`define PDC_PERIPH_PAGE 4'hf
`define PDC_STEP_BYTE 12'h001
`define PDC_STEP_WORD 12'h002

`endif

// ---- pdc_channel.v ----
// One DMA channel: its five registers, trigger choice, pending request
// and the address bookkeeping done when a transfer completes.
// Assumes the top module writes registers and pulses done_i once per
// finished byte or word transfer while it owns the system bus.
`timescale 1ns/100ps
`include "pdc_consts.vh"

module pdc_channel
(
    // Clock and reset.
    input wire clk,
    input wire resetn,
    // Register write port.
    input wire wr_en_i,
    input wire [2:0] wr_sel_i,
    input wire [7:0] wr_data_i,
    // Register read port.
    input wire [2:0] rd_sel_i,
    output reg [7:0] rd_data_o,
    // Trigger sources, indexed by the trigger code.
    input wire [6:0] trig_i,
    // Transfer engine handshake.
    input wire take_i,
    input wire done_i,
    output wire pend_o,
    output wire dir_o,
    output wire word_o,
    output wire [11:0] periph_addr_o,
    output wire [11:0] cur_addr_o,
    // Interrupt request pulse.
    output reg irq_o
);

    reg [7:0] ctl_r;
    reg [7:0] periph_r;
    reg [7:0] upper_r;
    reg [7:0] start_r;
    reg [7:0] end_r;
    reg [11:0] cur_r;
    reg pend_r;
    wire trig_hit;
    wire [2:0] trig_sel;
    wire [11:0] start_full;
    wire [11:0] end_full;
    wire last_xfer;

    // ============================================================
    // Address composition.
    assign start_full = {upper_r[3:0], start_r};
    assign end_full = {upper_r[7:4], end_r};
    assign periph_addr_o = {`PDC_PERIPH_PAGE, periph_r};
    assign cur_addr_o = cur_r;
    assign last_xfer = (cur_r == end_full);
    assign dir_o = ctl_r[`PDC_CTL_DIR];
    assign word_o = ctl_r[`PDC_CTL_WORD];
    assign pend_o = pend_r;

    // Code 7 has no source wired, so it never triggers.
    assign trig_sel = ctl_r[`PDC_CTL_TRIG_HI:`PDC_CTL_TRIG_LO];
    assign trig_hit = (trig_sel == `PDC_TRIG_NONE) ? 1'b0 :
                      trig_i[trig_sel];

    // Pending request; a new trigger wins over the engine taking one.
    always @(posedge clk)
    begin
        if (!resetn)
            pend_r <= 1'b0;
        else if (!ctl_r[`PDC_CTL_ENABLE])
            pend_r <= 1'b0;
        else if (trig_hit)
            pend_r <= 1'b1;
        else if (take_i)
            pend_r <= 1'b0;
    end

    // Registers and completion bookkeeping.
    always @(posedge clk)
    begin
        if (!resetn)
        begin
            ctl_r <= `PDC_CTL_RESET;
            periph_r <= 8'h00;
            upper_r <= 8'h00;
            start_r <= 8'h00;
            end_r <= 8'h00;
            cur_r <= 12'h000;
            irq_o <= 1'b0;
        end
        else
        begin
            irq_o <= 1'b0;
            if (wr_en_i)
            begin
                case (wr_sel_i)
                    `PDC_SEL_CONTROL: ctl_r <= wr_data_i;
                    `PDC_SEL_PERIPH: periph_r <= wr_data_i;
                    `PDC_SEL_UPPER:
                    begin
                        upper_r <= wr_data_i;
                        cur_r <= {wr_data_i[3:0], cur_r[7:0]};
                    end
                    `PDC_SEL_START:
                    begin
                        start_r <= wr_data_i;
                        cur_r <= {cur_r[11:8], wr_data_i};
                    end
                    `PDC_SEL_END: end_r <= wr_data_i;
                    default: ;
                endcase
            end
            // Hardware completion overrides a write in the same cycle.
            if (done_i)
            begin
                if (last_xfer)
                begin
                    cur_r <= start_full;
                    irq_o <= ctl_r[`PDC_CTL_IRQ_EN];
                    if (!ctl_r[`PDC_CTL_LOOP])
                        ctl_r[`PDC_CTL_ENABLE] <= 1'b0;
                end
                else if (ctl_r[`PDC_CTL_WORD])
                    cur_r <= cur_r + `PDC_STEP_WORD;
                else
                    cur_r <= cur_r + `PDC_STEP_BYTE;
            end
        end
    end

    // Read mux; the start register shows the next address to use.
    always @*
    begin
        case (rd_sel_i)
            `PDC_SEL_CONTROL: rd_data_o = ctl_r;
            `PDC_SEL_PERIPH: rd_data_o = periph_r;
            `PDC_SEL_UPPER: rd_data_o = upper_r;
            `PDC_SEL_START: rd_data_o = cur_r[7:0];
            `PDC_SEL_END: rd_data_o = end_r;
            default: rd_data_o = 8'h00;
        endcase
    end

endmodule

// ---- pdc_top_sva.sv ----
// Port-level checks for the two-channel DMA block.
// Assumes one bus slave, so HREADY follows HREADYOUT.
`timescale 1ns/100ps
module pdc_top_sva
(
    // Clock and reset.
    input logic CLK,
    input logic RESETN,
    // Register bus.
    input logic HSEL,
    input logic [31:0] HADDR,
    input logic [1:0] HTRANS,
    input logic HWRITE,
    input logic HREADY,
    input logic HREADYOUT,
    input logic HRESP,
    input logic [31:0] HRDATA,
    // System bus and interrupts.
    input logic BUS_REQ,
    input logic BUS_ACK,
    input logic MEM_RE,
    input logic MEM_WE,
    input logic CH0_IRQ,
    input logic CH1_IRQ
);
// ==========
// Checks
default clocking @(posedge CLK);
endclocking
default disable iff (!RESETN);
// Only a read address phase may move the read data.
wire rd_phase = HSEL && HREADY && HTRANS[1] && !HWRITE;
ready_okay_a: assert property (HREADYOUT && !HRESP)
    else $error("slave stalled or gave an error");
rdata_upper_a: assert property (HRDATA[31:8] == 24'h0)
    else $error("read data upper bits not zero");
unmapped_read_a: assert property (rd_phase && |HADDR[31:14] |=> !HRDATA)
    else $error("unmapped read gave data");
rdata_hold_a: assert property (!rd_phase |=> $stable(HRDATA))
    else $error("read data moved without a read");
mem_granted_a: assert property ((MEM_RE || MEM_WE) |-> BUS_REQ && BUS_ACK)
    else $error("memory strobe outside a granted tenure");
req_held_a: assert property (BUS_REQ && !BUS_ACK |=> BUS_REQ)
    else $error("bus request dropped before grant");
tenure_bound_a: assert property ($rose(BUS_REQ) |-> ##[1:20] !BUS_REQ)
    else $error("bus tenure too long");
ack_to_read_a: assert property (BUS_REQ && $rose(BUS_ACK) |-> ##[1:2] MEM_RE)
    else $error("no read after grant");
read_to_write_a: assert property (MEM_RE |-> ##[2:3] MEM_WE)
    else $error("read not followed by write");
irq_after_done_a: assert property ((CH0_IRQ || CH1_IRQ) |->
    $past(MEM_WE, 2) || $past(MEM_WE, 3))
    else $error("interrupt without a finished transfer");
irq_pulse_a: assert property (CH0_IRQ |=> !CH0_IRQ)
    else $error("interrupt longer than one cycle");
// Main scenarios: word tenure and both interrupts.
word_cov: cover property (MEM_WE ##[1:3] MEM_RE ##[2:3] MEM_WE);
irq0_cov: cover property (CH0_IRQ);
irq1_cov: cover property (CH1_IRQ);
endmodule
bind pdc_top pdc_top_sva chk
(
    .CLK(CLK), .RESETN(RESETN), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .HRDATA(HRDATA),
    .BUS_REQ(BUS_REQ), .BUS_ACK(BUS_ACK), .MEM_RE(MEM_RE),
    .MEM_WE(MEM_WE), .CH0_IRQ(CH0_IRQ), .CH1_IRQ(CH1_IRQ)
);

// ---- pdc_partner.sv ----
// CPU grant and register-file memory facing the DMA block.
// Assumes the block changes its strobes just after rising edges.
`timescale 1ns/100ps
module pdc_partner
(
    // Clock and reset.
    input wire clk,
    input wire resetn,
    // Grant side.
    input wire bus_req,
    input wire [1:0] ack_dly,
    output reg bus_ack,
    // Memory side.
    input wire [11:0] mem_addr,
    input wire mem_re,
    input wire mem_we,
    input wire [7:0] mem_wdata,
    output reg [7:0] mem_rdata
);
reg [7:0] mem_r [0:4095];
reg [1:0] wait_r;
integer i;
// ==========
// Each byte starts from a pattern tied to its own address.
initial
begin
    mem_rdata = 8'ha5;
    for (i = 0; i < 4096; i = i + 1)
        mem_r[i] = i[7:0] ^ {i[11:8], i[11:8]} ^ 8'h3c;
end
// Grant after a chosen delay, held for the whole tenure.
always @(posedge clk)
begin
    if (!resetn)
    begin
        bus_ack <= 1'b0;
        wait_r <= 2'h0;
    end
    else if (!bus_req)
    begin
        bus_ack <= 1'b0;
        wait_r <= 2'h0;
    end
    else if (wait_r >= ack_dly)
        bus_ack <= 1'b1;
    else
        wait_r <= wait_r + 2'h1;
end
// Read data stands one cycle, then toggles so stale data is not trusted.
always @(posedge clk)
begin
    mem_rdata <= mem_re ? mem_r[mem_addr] : ~mem_rdata;
    if (mem_we)
        mem_r[mem_addr] <= mem_wdata;
end
endmodule

// ---- test_peripheral_dma_channel_config.sv ----
// Self-checking bench for the two-channel DMA block.
// Assumes the design header, partner and checker compile first.
`timescale 1ns/100ps
`include "pdc_consts.vh"
`define CHK(got, exp) \
    begin \
        cmp_count++; \
        if ((got) !== (exp)) \
            miss("compared value differs"); \
    end
module test_peripheral_dma_channel_config;
logic clk, resetn, hwrite;
logic [1:0] htrans, ack_dly;
logic [31:0] haddr, hwdata;
logic [9:0] src;
wire hreadyout, hresp, bus_req, bus_ack, mem_re, mem_we, ch0_irq, ch1_irq;
wire [31:0] hrdata;
wire [11:0] mem_addr;
wire [7:0] mem_wdata, mem_rdata;
int num_errors = 0, cmp_count = 0, req_cnt = 0, irq0 = 0, irq1 = 0;
logic req_q = 1'b0;
// Source bits: timers 3:0, receive 6:4, transmit 9:7; code 7 fires all.
logic [9:0] row_mask [16] = '{10'h001, 10'h002, 10'h004, 10'h008,
    10'h010, 10'h020, 10'h040, 10'h3ff, 10'h001, 10'h002, 10'h004,
    10'h008, 10'h080, 10'h100, 10'h200, 10'h3ff};
// ==========
// Design and partner
pdc_top uut
(
    .CLK(clk), .RESETN(resetn), .HSEL(1'b1), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
    .HREADY(hreadyout), .HREADYOUT(hreadyout), .HRESP(hresp),
    .HRDATA(hrdata), .BUS_REQ(bus_req), .BUS_ACK(bus_ack),
    .MEM_ADDR(mem_addr), .MEM_RE(mem_re), .MEM_WE(mem_we),
    .MEM_WDATA(mem_wdata), .MEM_RDATA(mem_rdata), .TIMER_REQ(src[3:0]),
    .UART0_RX_VALID(src[4]), .UART1_RX_VALID(src[5]),
    .I2C_RX_REQ(src[6]), .UART0_TX_EMPTY(src[7]),
    .UART1_TX_EMPTY(src[8]), .I2C_TX_EMPTY(src[9]),
    .CH0_IRQ(ch0_irq), .CH1_IRQ(ch1_irq)
);
pdc_partner pm
(
    .clk(clk), .resetn(resetn), .bus_req(bus_req), .ack_dly(ack_dly),
    .bus_ack(bus_ack), .mem_addr(mem_addr), .mem_re(mem_re),
    .mem_we(mem_we), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata)
);
initial
begin
    clk = 1'b0;
    forever #5 clk = ~clk;
end
// Count tenures and interrupt pulses as they happen.
always @(posedge clk)
begin
    if (bus_req === 1'b1 && req_q !== 1'b1)
        req_cnt++;
    req_q <= bus_req;
    if (ch0_irq === 1'b1)
        irq0++;
    if (ch1_irq === 1'b1)
        irq1++;
end
// ==========
// Tasks
function automatic logic [7:0] pat(input logic [11:0] a);
    pat = a[7:0] ^ {a[11:8], a[11:8]} ^ 8'h3c;
endfunction
task miss(input string m);
    begin
        num_errors++;
        $display("MISMATCH t=%0t %s", $time, m);
    end
endtask
task tally_and_finish;
    begin
        $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    end
endtask
task bail;
    begin
        miss("wait ran out");
        tally_and_finish;
    end
endtask
// One single transfer: address phase, then data phase, each until ready.
task automatic ahb(input logic w, input logic [31:0] a,
    input logic [7:0] d, output logic [7:0] r);
    int n;
    begin
        n = 0;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 20);
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        do
        begin
            @(posedge clk);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 40);
        if (n >= 40)
            bail;
        r = hrdata[7:0];
    end
endtask
task automatic wr(input logic [11:0] i, input logic [7:0] d);
    logic [7:0] r;
    ahb(1'b1, {18'h0, i, 2'h0}, d, r);
endtask
task automatic rdchk(input logic [11:0] i, input logic [7:0] e);
    logic [7:0] r;
    begin
        ahb(1'b0, {18'h0, i, 2'h0}, 8'h00, r);
        `CHK(r, e)
    end
endtask
// Control goes last so the channel starts fully configured.
task automatic setup(input logic ch, input logic [7:0] p, u, s, e, c);
    logic [11:0] b;
    begin
        b = {8'h0, ch, 3'h0};
        wr(`PDC_IDX_CH0_PERIPH + b, p);
        wr(`PDC_IDX_CH0_UPPER + b, u);
        wr(`PDC_IDX_CH0_START + b, s);
        wr(`PDC_IDX_CH0_END + b, e);
        wr(`PDC_IDX_CH0_CONTROL + b, c);
    end
endtask
// Pulse sources for one cycle; when a transfer is due, wait it out.
task automatic fire(input logic [9:0] m, input logic go);
    int n;
    begin
        n = 0;
        src <= m;
        @(posedge clk);
        src <= 10'h0;
        while (go && bus_req !== 1'b1 && n < 40)
        begin
            @(posedge clk);
            n++;
        end
        if (n >= 40)
            bail;
        while (go && bus_req !== 1'b0 && n < 80)
        begin
            @(posedge clk);
            n++;
        end
        if (n >= 80)
            bail;
        repeat (go ? 4 : 20) @(posedge clk);
    end
endtask
// ==========
// Sequence
initial
begin
    int k, q, iq;
    logic ch;
    logic [2:0] code;
    logic [11:0] a, b;
    logic [7:0] p, c, e, r;
    resetn = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    src = 10'h0;
    ack_dly = 2'h0;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    `CHK(bus_req, 1'b0)
    rdchk(`PDC_IDX_CH0_CONTROL, `PDC_CTL_RESET);
    rdchk(`PDC_IDX_CH1_CONTROL, `PDC_CTL_RESET);
    // An address with high bits set must neither write nor read.
    ahb(1'b1, 32'h0004_3ec4, 8'hff, r);
    ahb(1'b0, 32'h0004_3ec4, 8'h00, r);
    `CHK(r, 8'h00)
    rdchk(`PDC_IDX_CH0_PERIPH, 8'h00);
    // Every trigger code on both channels, one single-pass byte each for codes 0 to 6, none for code 7.
    for (k = 0; k < 16; k++)
    begin
        ch = k[3];
        code = k[2:0];
        b = {8'h0, ch, 3'h0};
        a = {8'h40, k[3:0]};
        p = {4'h8, k[3:0]};
        c = {1'b1, 1'b0, code[0], code[1], 1'b0, code};
        ack_dly <= code[1:0];
        setup(ch, p, 8'h44, a[7:0], a[7:0], c);
        q = req_cnt;
        iq = ch ? irq1 : irq0;
        fire(~row_mask[k], 1'b0);
        `CHK(req_cnt, q)
        fire(row_mask[k], code != 3'h7);
        `CHK(req_cnt, q + (code != 3'h7))
        e = code == 3'h7 ? pat(a) : pat({4'hf, p});
        if (code[0])
            `CHK(pm.mem_r[a], e)
        else
            `CHK(pm.mem_r[{4'hf, p}], pat(a))
        `CHK(ch ? irq1 : irq0, iq + (code[1] && code != 3'h7))
        rdchk(`PDC_IDX_CH0_CONTROL + b, code == 3'h7 ? c : c & 8'h7f);
        rdchk(`PDC_IDX_CH0_START + b, a[7:0]);
    end
    // A disabled channel ignores its source.
    wr(`PDC_IDX_CH1_CONTROL, 8'h00);
    q = req_cnt;
    fire(10'h3ff, 1'b0);
    `CHK(req_cnt, q)
    // Looping word transfers with a slow grant, carrying into the nibble.
    ack_dly <= 2'h3;
    q = req_cnt;
    iq = irq0;
    setup(1'b0, 8'h50, 8'h32, 8'hfe, 8'h00, 8'hda);
    fire(10'h004, 1'b1);
    `CHK(pm.mem_r[12'hf50], pat(12'h2fe))
    `CHK(pm.mem_r[12'hf51], pat(12'h2ff))
    rdchk(`PDC_IDX_CH0_START, 8'h00);
    fire(10'h004, 1'b1);
    `CHK(pm.mem_r[12'hf50], pat(12'h300))
    `CHK(pm.mem_r[12'hf51], pat(12'h301))
    rdchk(`PDC_IDX_CH0_START, 8'hfe);
    rdchk(`PDC_IDX_CH0_CONTROL, 8'hda);
    `CHK(irq0, iq + 1)
    `CHK(req_cnt, q + 2)
    tally_and_finish;
end
endmodule
